// *** core/dpm_pkg.sv ***
// constants for the dual-port mailbox and token port controller
package dpm_pkg;
   // port geometry
   localparam int          ADDR_W     = 15;                 // word address width
   localparam int          DATA_W     = 18;                 // data bus width
   localparam int          TOK_SEL_W  = 3;                  // token latch select bits
   // mailbox locations
   localparam logic [14:0] MBX_LEFT   = 15'h7ffe;           // written by right, read by left
   localparam logic [14:0] MBX_RIGHT  = 15'h7fff;           // written by left, read by right
   // timing in ns
   localparam int          CLK_NS     = 4;                  // 250 MHz clock period
   localparam int          T_ACC_NS   = 20;                 // access strobe width
   localparam int          T_BAA_NS   = 20;                 // conflict flag settle after select
   localparam int          T_WH_NS    = 15;                 // hold after strobe end
   // timing in cycles, least times rounded up
   localparam logic [3:0]  C_ACC      = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  C_BAA      = 4'((T_BAA_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  C_WH       = 4'((T_WH_NS + CLK_NS - 1) / CLK_NS);
   // controller states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
   } dpm_state_t;
endpackage : dpm_pkg

// *** core/dpm_port_ctrl.sv ***
// host controller driving one port of the dual-port mailbox memory
`timescale 1ns/100ps
module dpm_port_ctrl #(
   parameter bit IS_LEFT = 1'b1,                            // which device port is driven
   parameter int NDEV    = 1                                // devices stacked in depth
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // user request side
   input  wire logic                      req,
   input  wire logic                      req_write,
   input  wire logic                      req_token,
   input  wire logic [dpm_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [dpm_pkg::DATA_W-1:0] req_wdata,
   output logic                           busy,
   output logic                           ack,
   output logic [dpm_pkg::DATA_W-1:0]     rdata,
   output logic                           token_granted,
   output logic                           conflict_seen,
   output logic                           mailbox_pending,
   // role and write blocking
   input  wire logic                      master_mode,
   input  wire logic                      inhibit_writes,
   // device port pins
   output logic                           port_select_n,
   output logic                           token_space_select_n,
   output logic                           rw_n,
   output logic                           oe_n,
   output logic [dpm_pkg::ADDR_W-1:0]     addr,
   input  wire logic [dpm_pkg::DATA_W-1:0] dq_i,
   output logic [dpm_pkg::DATA_W-1:0]     dq_o,
   output logic                           dq_oe_n,
   output logic                           role_select,
   input  wire logic [NDEV-1:0]           conflict_flag_i,
   output logic                           conflict_flag_o,
   output logic                           conflict_flag_oe_n,
   input  wire logic                      mailbox_flag_n
);
   // own mailbox, cleared by reading it
   localparam logic [14:0] MBX_OWN = IS_LEFT ? dpm_pkg::MBX_LEFT : dpm_pkg::MBX_RIGHT;

   // whole controller state
   typedef struct packed {
      dpm_pkg::dpm_state_t     st;        // sequencer state
      logic [3:0]              cnt;       // cycle counter
      logic                    init;      // power-up mailbox clear pending
      logic                    is_wr;     // current access writes
      logic                    is_tok;    // current access hits token space
      logic                    busy;      // access in flight
      logic                    ack;       // done pulse
      logic [17:0]             rdata;     // captured read word
      logic                    grant;     // token read shows ownership
      logic                    conf;      // conflict met on last access
      logic                    mbx;       // own mailbox flag seen
      logic                    sel_n;     // memory select pin
      logic                    tsel_n;    // token select pin
      logic                    rw_n;      // write strobe pin
      logic                    oe_n;      // output gate pin
      logic [14:0]             addr;      // address pins
      logic [17:0]             dq;        // write data pins
      logic                    dq_oe_n;   // data drive enable
      logic                    role;      // role select pin
      logic                    cf_o;      // slave flag level
      logic                    cf_oe_n;   // slave flag drive enable
   } dpm_ctrl_t;

   dpm_ctrl_t s_q;                        // registered state
   dpm_ctrl_t s_d;                        // next state
   logic      busy_ok;                    // no conflict reported

   // conflict view: master flags ANDed across the stack, never reported in slave role
   // depth stack AND
   assign busy_ok = !s_q.role || (&conflict_flag_i);

   // next-state logic
   always_comb begin
      s_d      = s_q;
      s_d.ack  = 1'b0;
      s_d.role = master_mode;
      s_d.cf_oe_n = master_mode;
      s_d.cf_o    = !inhibit_writes;
      s_d.mbx     = !mailbox_flag_n;
      case (s_q.st)
         dpm_pkg::ST_IDLE: begin
            s_d.sel_n   = 1'b1;
            s_d.tsel_n  = 1'b1;
            s_d.dq_oe_n = 1'b1;
            s_d.cnt     = 4'h0;
            if (s_q.init) begin
               s_d.is_wr  = 1'b0;
               s_d.is_tok = 1'b0;
               s_d.addr   = MBX_OWN;
               s_d.sel_n  = 1'b0;
               s_d.busy   = 1'b1;
               s_d.st     = dpm_pkg::ST_SETUP;
            end else if (req) begin
               s_d.is_wr  = req_write;
               s_d.is_tok = req_token;
               // token latch picked by low bits
               s_d.addr   = req_token ? {12'h000, req_addr[dpm_pkg::TOK_SEL_W-1:0]} : req_addr;
               s_d.dq     = req_wdata;
               s_d.sel_n  = req_token;
               s_d.tsel_n = !req_token;
               s_d.busy   = 1'b1;
               s_d.conf   = 1'b0;
               s_d.st     = dpm_pkg::ST_SETUP;
            end
         end
         dpm_pkg::ST_SETUP: begin
            // let the arbiter settle before any strobe
            if (s_q.cnt < dpm_pkg::C_BAA) begin
               s_d.cnt = s_q.cnt + 4'h1;
            end else if (!s_q.is_tok && !busy_ok) begin
               s_d.conf = 1'b1;
            end else begin
               s_d.rw_n    = !s_q.is_wr;
               s_d.oe_n    = s_q.is_wr;
               s_d.dq_oe_n = !s_q.is_wr;
               s_d.cnt     = 4'h0;
               s_d.st      = dpm_pkg::ST_STROBE;
            end
         end
         dpm_pkg::ST_STROBE: begin
            if (s_q.is_wr && !s_q.is_tok && !busy_ok) begin
               s_d.rw_n = 1'b1;
               s_d.conf = 1'b1;
               s_d.cnt  = 4'h0;
               s_d.st   = dpm_pkg::ST_SETUP;
            end else if (s_q.cnt < dpm_pkg::C_ACC - 4'h1) begin
               s_d.cnt = s_q.cnt + 4'h1;
            end else begin
               // end of strobe, capture read word
               s_d.rdata = s_q.is_wr ? s_q.rdata : dq_i;
               s_d.grant = s_q.is_tok && !s_q.is_wr ? !dq_i[0] : s_q.grant;
               s_d.rw_n  = 1'b1;
               s_d.oe_n  = 1'b1;
               s_d.cnt   = 4'h0;
               s_d.st    = dpm_pkg::ST_HOLD;
            end
         end
         dpm_pkg::ST_HOLD: begin
            // hold address and data after strobe
            if (s_q.cnt < dpm_pkg::C_WH - 4'h1) begin
               s_d.cnt = s_q.cnt + 4'h1;
            end else begin
               s_d.sel_n   = 1'b1;
               s_d.tsel_n  = 1'b1;
               s_d.dq_oe_n = 1'b1;
               s_d.busy    = 1'b0;
               s_d.ack     = !s_q.init;
               s_d.init    = 1'b0;
               s_d.st      = dpm_pkg::ST_IDLE;
            end
         end
         default: begin
            s_d.st = dpm_pkg::ST_IDLE;
         end
      endcase
   end

   // state register with reset values
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q         <= '0;
         s_q.st      <= dpm_pkg::ST_IDLE;
         s_q.init    <= 1'b1;
         s_q.sel_n   <= 1'b1;
         s_q.tsel_n  <= 1'b1;
         s_q.rw_n    <= 1'b1;
         s_q.oe_n    <= 1'b1;
         s_q.dq_oe_n <= 1'b1;
         s_q.role    <= 1'b1;
         s_q.cf_o    <= 1'b1;
         s_q.cf_oe_n <= 1'b1;
         s_q.busy    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign busy                 = s_q.busy;
   assign ack                  = s_q.ack;
   assign rdata                = s_q.rdata;
   assign token_granted        = s_q.grant;
   assign conflict_seen        = s_q.conf;
   assign mailbox_pending      = s_q.mbx;
   assign port_select_n        = s_q.sel_n;
   assign token_space_select_n = s_q.tsel_n;
   assign rw_n                 = s_q.rw_n;
   assign oe_n                 = s_q.oe_n;
   assign addr                 = s_q.addr;
   assign dq_o                 = s_q.dq;
   assign dq_oe_n              = s_q.dq_oe_n;
   assign role_select          = s_q.role;
   assign conflict_flag_o      = s_q.cf_o;
   assign conflict_flag_oe_n   = s_q.cf_oe_n;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seq_wr_start;
      $fell(s_q.rw_n);
   endsequence

   chk_token_select: assert property (!s_q.tsel_n |-> s_q.sel_n)
      else $error("token space accessed with memory select active");
   chk_slave_drive: assert property (
      !master_mode ##1 1 |-> !conflict_flag_oe_n && conflict_flag_o == !$past(inhibit_writes))
      else $error("slave conflict flag not driven from inhibit request");
   chk_write_stall: assert property (seq_wr_start |-> $past(busy_ok) || $past(s_q.is_tok))
      else $error("write strobe started while conflict flagged");
   chk_depth_and: assert property (
      s_q.role && !(&conflict_flag_i) && !s_q.is_tok && s_q.st == dpm_pkg::ST_SETUP |=> s_q.rw_n)
      else $error("stack conflict ignored");
   // one-cycle done pulse, idle with it; next request may follow at once
   chk_ack_pulse: assert property (ack |-> !busy ##1 !ack)
      else $error("ack longer than one cycle");
   chk_role_pin: assert property (##1 role_select == $past(master_mode))
      else $error("role select not following mode");
endmodule : dpm_port_ctrl

// *** bench/dpm_dev.sv ***
// behavioural model of the dual-port memory: storage, mailboxes, tokens, conflict flags
`timescale 1ns/100ps
module dpm_dev (
   // sampling clock and role pin
   input  wire logic        clk,
   input  wire logic        role,
   // port pins, index 0 left, 1 right
   input  wire logic        sel_n  [2],
   input  wire logic        tok_n  [2],
   input  wire logic        rw_n   [2],
   input  wire logic        oe_n   [2],
   input  wire logic [14:0] addr   [2],
   input  wire logic [17:0] din    [2],
   output logic [17:0]      dout   [2],
   input  wire logic        fl_in  [2],
   output logic             fl_out [2],
   output logic             mbx_n  [2]
);
   logic [17:0] mem [32768];        // storage words
   logic [1:0]  own [8];            // token holder, 0 free
   logic        pend [2][8];        // queued token requests
   logic [17:0] tlat [2];           // token read latch
   logic [17:0] last [2];           // last driven word
   logic        prw [2], poe [2];   // previous strobe levels
   int          t0 [2], cyc;        // select arrival
   // flags start set, host must clear them
   initial begin
      own = '{default: 2'h0};
      pend = '{default: 1'b0};
      mbx_n = '{default: 1'b0};
      last = '{default: 18'h0};
      prw = '{default: 1'b1};
      poe = '{default: 1'b1};
      t0 = '{default: 0};
      cyc = 0;
   end
   always @* begin
      for (int s = 0; s < 2; s++) begin
         fl_out[s] = !(!sel_n[0] && !sel_n[1] && addr[0] == addr[1]
                       && (t0[s] > t0[1-s] || (t0[s] == t0[1-s] && s == 1)));
         dout[s] = (!oe_n[s] && !tok_n[s]) ? tlat[s] :
                   (!oe_n[s] && !sel_n[s]) ? mem[addr[s]] : ~last[s];
      end
   end
   // pin sampling each cycle
   always @(posedge clk) begin : smp
      logic       ok;
      logic [2:0] k;
      cyc++;
      for (int s = 0; s < 2; s++) begin
         ok = role ? fl_out[s] : fl_in[s];
         k = addr[s][2:0];
         if (sel_n[s]) t0[s] = cyc;
         if (!sel_n[s] && !rw_n[s] && ok) begin
            mem[addr[s]] = din[s];
            if (addr[s] == (s ? 15'h7ffe : 15'h7fff)) mbx_n[1-s] <= 1'b0;
         end
         if (!sel_n[s] && !oe_n[s] && addr[s] == (s ? 15'h7fff : 15'h7ffe)) mbx_n[s] <= 1'b1;
         if (!tok_n[s] && sel_n[s] && !rw_n[s] && prw[s]) begin
            if (!din[s][0]) begin
               if (own[k] == 2'h0) own[k] = 2'(s + 1);
               else if (own[k] != 2'(s + 1)) pend[s][k] = 1'b1;
            end else if (own[k] == 2'(s + 1)) begin
               own[k] = pend[1-s][k] ? 2'(2 - s) : 2'h0;
               pend[1-s][k] = 1'b0;
            end else pend[s][k] = 1'b0;
         end
         if (!(oe_n[s] | tok_n[s]) && poe[s]) tlat[s] = {18{own[k] != 2'(s + 1)}};
         if (!oe_n[s]) last[s] = dout[s];
         prw[s] = rw_n[s];
         poe[s] = oe_n[s] | tok_n[s];
      end
   end
endmodule : dpm_dev

// *** bench/testbench.sv ***
// self-checking bench: two port controllers facing the memory model
`timescale 1ns/100ps
module testbench;
   logic clk = 0, rst = 1, ms;
   logic req [2], wr [2], tk [2], inh [2], busy [2], ack [2], tg [2], cs [2], mp [2];
   logic sel_n [2], tok_n [2], rw_n [2], oe_n [2], doe [2], rs [2], fo [2], foe [2];
   logic ffo [2], fl [2], mb [2];
   logic [14:0] ra [2], pa [2];
   logic [17:0] wd [2], rd [2], dq [2], dout [2], dqb [2];
   logic [18:0] q [2][$], e;
   logic [3:0]  tseq [10] = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hd, 4'h7, 4'ha, 4'hf, 4'h1, 4'h7};
   logic [31:0] seed = 32'h1e0419b7;
   int          mismatches = 0, total_checks = 0;
   always #2 clk = ~clk;
   for (genvar g = 0; g < 2; g++) begin : port
      dpm_port_ctrl #(.IS_LEFT(g == 0), .NDEV(1)) dut (
         .clk(clk), .rst(rst), .req(req[g]), .req_write(wr[g]), .req_token(tk[g]),
         .req_addr(ra[g]), .req_wdata(wd[g]), .busy(busy[g]), .ack(ack[g]), .rdata(rd[g]),
         .token_granted(tg[g]), .conflict_seen(cs[g]), .mailbox_pending(mp[g]),
         .master_mode(ms), .inhibit_writes(inh[g]), .port_select_n(sel_n[g]),
         .token_space_select_n(tok_n[g]), .rw_n(rw_n[g]), .oe_n(oe_n[g]), .addr(pa[g]),
         .dq_i(dout[g]), .dq_o(dq[g]), .dq_oe_n(doe[g]), .role_select(rs[g]),
         .conflict_flag_i(fl[g]), .conflict_flag_o(fo[g]), .conflict_flag_oe_n(foe[g]),
         .mailbox_flag_n(mb[g]));
      // conflict pin level from both drivers
      assign fl[g] = !foe[g] ? fo[g] : rs[0] ? ffo[g] : 1'b1;
      // undriven data bus shows the inverse of the last word
      assign dqb[g] = !doe[g] ? dq[g] : ~dq[g];
   end
   dpm_dev dev (.clk(clk), .role(rs[0]), .sel_n(sel_n), .tok_n(tok_n), .rw_n(rw_n),
      .oe_n(oe_n), .addr(pa), .din(dqb), .dout(dout), .fl_in(fl), .fl_out(ffo), .mbx_n(mb));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : pause
   // bounded wait for idle (k=0) or ack (k=1)
   task automatic wt(input int p, input bit k);
      int n;
      for (n = 0; n < 400 && (k ? ack[p] : busy[p]) !== k; n++) pause(1);
      if (n == 400) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         summarize();
      end
   endtask : wt
   // one user access; note of the expected read word queued first
   task automatic acc(input int p, input logic w, input logic t, input logic [14:0] a,
                      input logic [17:0] d, input logic c, input logic [17:0] x);
      wt(p, 0);
      q[p].push_back({c, x});
      req[p] = 1;
      wr[p] = w;
      tk[p] = t;
      ra[p] = a;
      wd[p] = d;
      pause(1);
      req[p] = 0;
      wt(p, 1);
   endtask : acc
   // pop the oldest note on each completed access, compare the read word when the note expects one
   always @(posedge clk)
      for (int p = 0; p < 2; p++)
         if (ack[p] === 1'b1 && q[p].size() > 0) begin
            e = q[p].pop_front();
            if (e[18]) chk(rd[p], e[17:0]);
         end
   initial begin
      req = '{default: 1'b0}; wr = req; tk = req; inh = req;
      ra = '{default: 15'h0};
      wd = '{default: 18'h0};
      ms = 1;
      pause(3);
      rst = 0;
      wt(0, 0);
      wt(1, 0);
      chk({17'h0, mp[0] | mp[1]}, 18'h0);
      for (int p = 0; p < 2; p++) begin
         seed = lfsr(seed);
         acc(p, 1, 0, p ? 15'h7ffe : 15'h7fff, seed[17:0], 0, 0);
         pause(2);
         chk({17'h0, mp[1-p]}, 18'h1);
         acc(1 - p, 0, 0, p ? 15'h7ffe : 15'h7fff, 0, 1, seed[17:0]);
         pause(2);
         chk({17'h0, mp[1-p]}, 18'h0);
      end
      $display("test mailbox done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         acc(i % 2, 1, 0, {1'b0, seed[31:18]}, seed[17:0], 0, 0);
         acc(1 - i % 2, 0, 0, {1'b0, seed[31:18]}, 0, 1, seed[17:0]);
      end
      $display("test memory done");
      for (int k = 0; k < 8; k++)
         foreach (tseq[r]) begin
            seed = lfsr(seed);
            acc(int'(tseq[r][3]), 1, 1, 15'(k), {seed[17:1], tseq[r][2]}, 0, 0);
            for (int p = 0; p < 2; p++) begin
               acc(p, 0, 1, 15'(k), 0, 1, {18{tseq[r][1-p]}});
               chk({17'h0, tg[p]}, {17'h0, !tseq[r][1-p]});
            end
         end
      $display("test tokens done");
      seed = lfsr(seed);
      fork
         acc(0, 1, 0, 15'h0123, seed[17:0], 0, 0);
         begin pause(1); acc(1, 1, 0, 15'h0123, ~seed[17:0], 0, 0); end
      join
      chk({17'h0, cs[1]}, 18'h1);
      chk({17'h0, cs[0]}, 18'h0);
      acc(0, 0, 0, 15'h0123, 0, 1, ~seed[17:0]);
      $display("test conflict done");
      ms = 0;
      inh[0] = 1;
      pause(2);
      acc(0, 1, 0, 15'h0123, seed[17:0], 0, 0);
      acc(1, 0, 0, 15'h0123, 0, 1, ~seed[17:0]);
      inh[0] = 0;
      pause(2);
      acc(0, 1, 0, 15'h0123, seed[17:0], 0, 0);
      acc(1, 0, 0, 15'h0123, 0, 1, seed[17:0]);
      $display("test slave done");
      summarize();
   end
endmodule : testbench
